// *** shared/rss_pkg.sv ***
// Package for the run/sleep/restart sequencer: register map, field codes,
// reset values and tick timing. Assumes a 40 MHz system clock.
package rss_pkg;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Register offsets (word index on the plain register port)
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_LIMIT_ACTION = 5'h01;
  localparam logic [4:0] ADDR_WAKE_DELAY = 5'h02;
  localparam logic [4:0] ADDR_RESTART_EN = 5'h03;
  localparam logic [4:0] ADDR_RESTART_WAIT = 5'h04;
  localparam logic [4:0] ADDR_START_DELAY = 5'h05;
  localparam logic [4:0] ADDR_STOP_HOLD_DLY = 5'h06;
  localparam logic [4:0] ADDR_ZERO_FREQ_SEL = 5'h07;
  localparam logic [4:0] ADDR_EMERG_DECEL = 5'h08;
  localparam logic [4:0] ADDR_SCURVE_START = 5'h09;
  localparam logic [4:0] ADDR_SCURVE_END = 5'h0a;
  localparam logic [4:0] ADDR_SHORT_CURRENT = 5'h0b;
  localparam logic [4:0] ADDR_SHORT_START = 5'h0c;
  localparam logic [4:0] ADDR_SHORT_STOP = 5'h0d;
  localparam logic [4:0] ADDR_DC_STOP_TIME = 5'h0e;
  localparam logic [4:0] ADDR_START_MODE = 5'h0f;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // Limits, in 0.1 s or 0.1 % units
  localparam logic [15:0] MAX_LONG_TIME = 16'h8ca0;
  localparam logic [15:0] MAX_START_DELAY = 16'h1770;
  localparam logic [15:0] MAX_SECTION_TIME = 16'h01f4;
  localparam logic [15:0] MAX_EMERG_DECEL = 16'h0258;
  localparam logic [15:0] MAX_SHORT_CURRENT = 16'h05dc;
  // Reset values
  localparam logic [15:0] RST_WAKE_DELAY = 16'h0000;
  localparam logic [15:0] RST_RESTART_WAIT = 16'h000a;
  localparam logic [15:0] RST_START_DELAY = 16'h0000;
  localparam logic [15:0] RST_STOP_HOLD_DLY = 16'h0000;
  localparam logic [15:0] RST_EMERG_DECEL = 16'h0014;
  localparam logic [15:0] RST_SCURVE = 16'h0001;
  localparam logic [15:0] RST_SHORT = 16'h0000;
  localparam logic [15:0] RST_DC_STOP_TIME = 16'h0000;
  // Codes
  localparam logic [1:0] ACT_RUN_AT_LIMIT = 2'h0;
  localparam logic [1:0] ACT_STOP = 2'h1;
  localparam logic [1:0] ACT_SLEEP = 2'h2;
  localparam logic [1:0] ZF_NO_VOLTAGE = 2'h0;
  localparam logic [1:0] ZF_VOLTAGE = 2'h1;
  localparam logic [1:0] ZF_DC_CURRENT = 2'h2;
  localparam logic [1:0] START_DIRECT = 2'h0;
  // Control register bits
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PWR_OK_BIT = 1;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_PWR_WAIT = 8'b0000_0010,
    ST_START_DLY = 8'b0000_0100,
    ST_SHORT_START = 8'b0000_1000,
    ST_RUN = 8'b0001_0000,
    ST_SLEEP = 8'b0010_0000,
    ST_SHORT_STOP = 8'b0100_0000,
    ST_DC_STOP = 8'b1000_0000
  } rss_state_t;

  // Clamp a setting to its documented range
  function automatic logic [15:0] rss_clamp(input logic [15:0] v,
                                            input logic [15:0] lim);
    rss_clamp = (v > lim) ? lim : v;
  endfunction : rss_clamp
endpackage : rss_pkg

// *** hdl/rss_tick_timer.sv ***
// Hold timer counting 0.1 s ticks while its condition stands.
// Assumes a shared tick pulse from the parent sequencer.
`timescale 1ns/1ps
module rss_tick_timer
  import rss_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [W-1:0] limit,
  // Status
  output logic done
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (!run) begin
      count_next = '0;
    end else if (tick && count_reg < limit) begin
      count_next = count_reg + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // Zero limit completes at once while the condition stands
  assign done = run && (count_reg >= limit);
endmodule : rss_tick_timer

// *** hdl/rss_sequencer.sv ***
// Run-state sequencer: low-limit action, sleep/wake, power-on restart,
// start delay and short-circuit/DC brake phases.
// Assumes synchronous inputs, one 40 MHz clock, and a plain register port.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // Drive-side status
  input wire logic setBelowLimit,
  input wire logic runBelowLimit,
  input wire logic belowBrakeFreq,
  input wire logic atZeroFreq,
  // Drive commands
  output logic driveEnable,
  output logic runAtLowerLimit,
  output logic shortBrakeActive,
  output logic dcBrakeActive,
  output logic zeroFreqVoltage,
  output logic zeroFreqDcCurrent,
  output logic [15:0] shortBrakeCurrent,
  output logic [15:0] decelScurveStartTime,
  output logic [15:0] decelScurveEndTime,
  output logic [15:0] emergencyDecelTime,
  output logic [15:0] stopSpeedHoldDelay
);
  // Settings
  logic runCmd_reg, runCmd_next;
  logic pwrOk_reg, pwrOk_next;
  logic [1:0] belowLimitActionSel_reg, belowLimitActionSel_next;
  logic [15:0] wakeDelayTime_reg, wakeDelayTime_next;
  logic powerLossRestartEn_reg, powerLossRestartEn_next;
  logic [15:0] powerLossRestartWait_reg, powerLossRestartWait_next;
  logic [15:0] runStartDelay_reg, runStartDelay_next;
  logic [15:0] stopHold_reg, stopHold_next;
  logic [1:0] zeroFreqOutputSel_reg, zeroFreqOutputSel_next;
  logic [15:0] emergDecel_reg, emergDecel_next;
  logic [15:0] scStart_reg, scStart_next;
  logic [15:0] scEnd_reg, scEnd_next;
  logic [15:0] shortCur_reg, shortCur_next;
  logic [15:0] shortStartHold_reg, shortStartHold_next;
  logic [15:0] shortStopHold_reg, shortStopHold_next;
  logic [15:0] dcStopTime_reg, dcStopTime_next;
  logic [1:0] startModeSel_reg, startModeSel_next;
  logic [15:0] rdata_reg, rdata_next;
  // Sequencer
  rss_state_t state_reg, state_next;
  logic autoRun_reg, autoRun_next;
  logic [31:0] div_reg, div_next;
  logic tick;
  logic wakeDone, pwrDone, startDone, shortStartDone, shortStopDone, dcDone;
  logic stopping;

  always_comb begin
    runCmd_next = runCmd_reg;
    pwrOk_next = pwrOk_reg;
    belowLimitActionSel_next = belowLimitActionSel_reg;
    wakeDelayTime_next = wakeDelayTime_reg;
    powerLossRestartEn_next = powerLossRestartEn_reg;
    powerLossRestartWait_next = powerLossRestartWait_reg;
    runStartDelay_next = runStartDelay_reg;
    stopHold_next = stopHold_reg;
    zeroFreqOutputSel_next = zeroFreqOutputSel_reg;
    emergDecel_next = emergDecel_reg;
    scStart_next = scStart_reg;
    scEnd_next = scEnd_reg;
    shortCur_next = shortCur_reg;
    shortStartHold_next = shortStartHold_reg;
    shortStopHold_next = shortStopHold_reg;
    dcStopTime_next = dcStopTime_reg;
    startModeSel_next = startModeSel_reg;
    if (regWrite) begin
      unique case (regAddr)
        ADDR_CTRL: begin
          runCmd_next = regWdata[CTRL_RUN_BIT];
          pwrOk_next = regWdata[CTRL_PWR_OK_BIT];
        end
        ADDR_LIMIT_ACTION: begin
          // Code 3 is not defined and is ignored
          if (regWdata[1:0] != 2'h3) begin
            belowLimitActionSel_next = regWdata[1:0];
          end
        end
        ADDR_WAKE_DELAY: wakeDelayTime_next =
            rss_clamp(regWdata, MAX_LONG_TIME);
        ADDR_RESTART_EN: powerLossRestartEn_next = regWdata[0];
        ADDR_RESTART_WAIT: powerLossRestartWait_next =
            rss_clamp(regWdata, MAX_LONG_TIME);
        ADDR_START_DELAY: runStartDelay_next =
            rss_clamp(regWdata, MAX_START_DELAY);
        ADDR_STOP_HOLD_DLY: stopHold_next =
            rss_clamp(regWdata, MAX_START_DELAY);
        ADDR_ZERO_FREQ_SEL: begin
          if (regWdata[1:0] != 2'h3) begin
            zeroFreqOutputSel_next = regWdata[1:0];
          end
        end
        ADDR_EMERG_DECEL: emergDecel_next =
            rss_clamp(regWdata, MAX_EMERG_DECEL);
        ADDR_SCURVE_START: scStart_next =
            rss_clamp(regWdata, MAX_SECTION_TIME);
        ADDR_SCURVE_END: scEnd_next =
            rss_clamp(regWdata, MAX_SECTION_TIME);
        ADDR_SHORT_CURRENT: shortCur_next =
            rss_clamp(regWdata, MAX_SHORT_CURRENT);
        ADDR_SHORT_START: shortStartHold_next =
            rss_clamp(regWdata, MAX_SECTION_TIME);
        ADDR_SHORT_STOP: shortStopHold_next =
            rss_clamp(regWdata, MAX_SECTION_TIME);
        ADDR_DC_STOP_TIME: dcStopTime_next =
            rss_clamp(regWdata, MAX_SECTION_TIME);
        ADDR_START_MODE: startModeSel_next = regWdata[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        ADDR_CTRL: rdata_next = {14'h0000, pwrOk_reg, runCmd_reg};
        ADDR_LIMIT_ACTION: rdata_next = {14'h0000, belowLimitActionSel_reg};
        ADDR_WAKE_DELAY: rdata_next = wakeDelayTime_reg;
        ADDR_RESTART_EN: rdata_next = {15'h0000, powerLossRestartEn_reg};
        ADDR_RESTART_WAIT: rdata_next = powerLossRestartWait_reg;
        ADDR_START_DELAY: rdata_next = runStartDelay_reg;
        ADDR_STOP_HOLD_DLY: rdata_next = stopHold_reg;
        ADDR_ZERO_FREQ_SEL: rdata_next = {14'h0000, zeroFreqOutputSel_reg};
        ADDR_EMERG_DECEL: rdata_next = emergDecel_reg;
        ADDR_SCURVE_START: rdata_next = scStart_reg;
        ADDR_SCURVE_END: rdata_next = scEnd_reg;
        ADDR_SHORT_CURRENT: rdata_next = shortCur_reg;
        ADDR_SHORT_START: rdata_next = shortStartHold_reg;
        ADDR_SHORT_STOP: rdata_next = shortStopHold_reg;
        ADDR_DC_STOP_TIME: rdata_next = dcStopTime_reg;
        ADDR_START_MODE: rdata_next = {14'h0000, startModeSel_reg};
        ADDR_STATUS: rdata_next = {7'h00, autoRun_reg, 8'(state_reg)};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      runCmd_reg <= 1'b0;
      pwrOk_reg <= 1'b0;
      belowLimitActionSel_reg <= ACT_RUN_AT_LIMIT;
      wakeDelayTime_reg <= RST_WAKE_DELAY;
      powerLossRestartEn_reg <= 1'b0;
      powerLossRestartWait_reg <= RST_RESTART_WAIT;
      runStartDelay_reg <= RST_START_DELAY;
      stopHold_reg <= RST_STOP_HOLD_DLY;
      zeroFreqOutputSel_reg <= ZF_NO_VOLTAGE;
      emergDecel_reg <= RST_EMERG_DECEL;
      scStart_reg <= RST_SCURVE;
      scEnd_reg <= RST_SCURVE;
      shortCur_reg <= RST_SHORT;
      shortStartHold_reg <= RST_SHORT;
      shortStopHold_reg <= RST_SHORT;
      dcStopTime_reg <= RST_DC_STOP_TIME;
      startModeSel_reg <= START_DIRECT;
      rdata_reg <= 16'h0000;
    end else begin
      runCmd_reg <= runCmd_next;
      pwrOk_reg <= pwrOk_next;
      belowLimitActionSel_reg <= belowLimitActionSel_next;
      wakeDelayTime_reg <= wakeDelayTime_next;
      powerLossRestartEn_reg <= powerLossRestartEn_next;
      powerLossRestartWait_reg <= powerLossRestartWait_next;
      runStartDelay_reg <= runStartDelay_next;
      stopHold_reg <= stopHold_next;
      zeroFreqOutputSel_reg <= zeroFreqOutputSel_next;
      emergDecel_reg <= emergDecel_next;
      scStart_reg <= scStart_next;
      scEnd_reg <= scEnd_next;
      shortCur_reg <= shortCur_next;
      shortStartHold_reg <= shortStartHold_next;
      shortStopHold_reg <= shortStopHold_next;
      dcStopTime_reg <= dcStopTime_next;
      startModeSel_reg <= startModeSel_next;
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;

  // Shared 0.1 s tick; parameter lets simulation shorten it
  always_comb begin
    div_next = div_reg + 32'h0000_0001;
    if (div_reg >= 32'(TICK_DIV - 1)) begin
      div_next = 32'h0000_0000;
    end
  end
  assign tick = (div_reg >= 32'(TICK_DIV - 1));

  // Either software run or the pending power-on auto run counts as command
  logic runReq;
  assign runReq = runCmd_reg || autoRun_reg;
  assign stopping = !runReq;

  rss_tick_timer u_wake (.mclk(mclk), .reset(reset), .tick(tick),
    .run(state_reg == ST_SLEEP && !setBelowLimit),
    .limit(wakeDelayTime_reg), .done(wakeDone));
  rss_tick_timer u_pwr (.mclk(mclk), .reset(reset), .tick(tick),
    .run(state_reg == ST_PWR_WAIT), .limit(powerLossRestartWait_reg),
    .done(pwrDone));
  rss_tick_timer u_start (.mclk(mclk), .reset(reset), .tick(tick),
    .run(state_reg == ST_START_DLY), .limit(runStartDelay_reg),
    .done(startDone));
  rss_tick_timer u_sstart (.mclk(mclk), .reset(reset), .tick(tick),
    .run(state_reg == ST_SHORT_START), .limit(shortStartHold_reg),
    .done(shortStartDone));
  rss_tick_timer u_sstop (.mclk(mclk), .reset(reset), .tick(tick),
    .run(state_reg == ST_SHORT_STOP), .limit(shortStopHold_reg),
    .done(shortStopDone));
  rss_tick_timer u_dc (.mclk(mclk), .reset(reset), .tick(tick),
    .run(state_reg == ST_DC_STOP), .limit(dcStopTime_reg),
    .done(dcDone));

  always_comb begin
    state_next = state_reg;
    autoRun_next = autoRun_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (powerLossRestartEn_reg && pwrOk_reg && !autoRun_reg) begin
          state_next = ST_PWR_WAIT;
        end else if (runReq) begin
          state_next = ST_START_DLY;
        end
      end
      ST_PWR_WAIT: begin
        if (!powerLossRestartEn_reg || !pwrOk_reg) begin
          state_next = ST_IDLE;
        end else if (pwrDone) begin
          autoRun_next = 1'b1;
          state_next = ST_START_DLY;
        end
      end
      ST_START_DLY: begin
        if (stopping) begin
          state_next = ST_IDLE;
        end else if (startDone) begin
          if (startModeSel_reg == START_DIRECT &&
              shortStartHold_reg != 16'h0000) begin
            state_next = ST_SHORT_START;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_SHORT_START: begin
        if (stopping) begin
          state_next = ST_IDLE;
        end else if (shortStartDone) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stopping) begin
          if (belowBrakeFreq && shortStopHold_reg != 16'h0000) begin
            state_next = ST_SHORT_STOP;
          end else if (belowBrakeFreq) begin
            state_next = ST_IDLE;
          end
        end else if (belowLimitActionSel_reg == ACT_SLEEP &&
                     runBelowLimit) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (stopping) begin
          state_next = ST_IDLE;
        end else if (belowLimitActionSel_reg != ACT_SLEEP) begin
          state_next = ST_RUN;
        end else if (wakeDone) begin
          state_next = ST_RUN;
        end
      end
      ST_SHORT_STOP: begin
        if (shortStopDone) begin
          state_next = ST_DC_STOP;
        end
      end
      ST_DC_STOP: begin
        if (dcDone) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Auto run ends when software drops power-ok or disables the power-loss restart
    if (!pwrOk_reg || !powerLossRestartEn_reg) begin
      autoRun_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      autoRun_reg <= 1'b0;
      div_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      autoRun_reg <= autoRun_next;
      div_reg <= div_next;
    end
  end

  // Stop and sleep actions coast while set frequency is under the limit
  logic coastStop;
  assign coastStop = belowLimitActionSel_reg inside {ACT_STOP, ACT_SLEEP} &&
                     setBelowLimit;

  always_ff @(posedge mclk) begin
    if (reset) begin
      driveEnable <= 1'b0;
      runAtLowerLimit <= 1'b0;
      shortBrakeActive <= 1'b0;
      dcBrakeActive <= 1'b0;
      zeroFreqVoltage <= 1'b0;
      zeroFreqDcCurrent <= 1'b0;
    end else begin
      driveEnable <= (state_next == ST_RUN && !coastStop) ||
                     state_next == ST_SHORT_START ||
                     state_next == ST_SHORT_STOP ||
                     state_next == ST_DC_STOP;
      runAtLowerLimit <= state_next == ST_RUN && setBelowLimit &&
                         belowLimitActionSel_reg == ACT_RUN_AT_LIMIT;
      shortBrakeActive <= state_next == ST_SHORT_START ||
                          state_next == ST_SHORT_STOP;
      dcBrakeActive <= state_next == ST_DC_STOP;
      zeroFreqVoltage <= state_next == ST_RUN && atZeroFreq &&
                         zeroFreqOutputSel_reg == ZF_VOLTAGE;
      zeroFreqDcCurrent <= state_next == ST_RUN && atZeroFreq &&
                           zeroFreqOutputSel_reg == ZF_DC_CURRENT;
    end
  end

  assign shortBrakeCurrent = shortCur_reg;
  assign decelScurveStartTime = scStart_reg;
  assign decelScurveEndTime = scEnd_reg;
  assign emergencyDecelTime = emergDecel_reg;
  assign stopSpeedHoldDelay = stopHold_reg;
endmodule : rss_sequencer

// *** verification/rss_sequencer_assertions.sv ***
// Port checker for the run/sleep/restart sequencer.
// Assumes it is bound to rss_sequencer and sees only its ports.
`timescale 1ns/1ps
module rss_sequencer_assertions
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  // Drive status and commands
  input wire logic setBelowLimit,
  input wire logic driveEnable,
  input wire logic runAtLowerLimit,
  input wire logic shortBrakeActive,
  input wire logic dcBrakeActive,
  input wire logic zeroFreqVoltage,
  input wire logic zeroFreqDcCurrent,
  input wire logic [15:0] shortBrakeCurrent,
  input wire logic [15:0] decelScurveStartTime,
  input wire logic [15:0] decelScurveEndTime
);
  logic [1:0] actSel_reg, actSel_next, zfSel_reg, zfSel_next;
  logic wEnd, wCur;
  assign wEnd = regWrite && regAddr == ADDR_SCURVE_END;
  assign wCur = regWrite && regAddr == ADDR_SHORT_CURRENT;
  // Shadow of the two code selects; code 3 is refused by the block
  always_comb begin
    actSel_next = actSel_reg;
    zfSel_next = zfSel_reg;
    if (regWrite && regWdata[1:0] != 2'h3) begin
      if (regAddr == ADDR_LIMIT_ACTION) actSel_next = regWdata[1:0];
      if (regAddr == ADDR_ZERO_FREQ_SEL) zfSel_next = regWdata[1:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      actSel_reg <= ACT_RUN_AT_LIMIT;
      zfSel_reg <= ZF_NO_VOLTAGE;
    end else begin
      actSel_reg <= actSel_next;
      zfSel_reg <= zfSel_next;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence shortEnds;
    $fell(shortBrakeActive);
  endsequence
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data not zero outside read slot");
  a_action_readback: assert property ($past(regRead) &&
    $past(regAddr) == ADDR_LIMIT_ACTION |-> regRdata == {14'h0, actSel_reg})
    else $error("action select readback wrong");
  a_stop_coast: assert property (actSel_reg == ACT_STOP &&
    $past(actSel_reg) == ACT_STOP && $past(actSel_reg, 2) == ACT_STOP &&
    $past(setBelowLimit) |-> !driveEnable)
    else $error("drive kept on under stop action");
  a_limit_drive: assert property (runAtLowerLimit |-> driveEnable)
    else $error("clamped at lower limit without drive");
  a_brake_excl: assert property (
    !(shortBrakeActive && dcBrakeActive))
    else $error("short and DC brake together");
  a_short_next: assert property (
    shortEnds |-> dcBrakeActive || driveEnable)
    else $error("short brake not followed by DC brake or run");
  a_zf_none: assert property (zfSel_reg == ZF_NO_VOLTAGE &&
    $past(zfSel_reg) == ZF_NO_VOLTAGE && $past(zfSel_reg, 2) == ZF_NO_VOLTAGE
    |-> !zeroFreqVoltage && !zeroFreqDcCurrent)
    else $error("zero frequency output while none selected");
  a_zf_excl: assert property (!(zeroFreqVoltage && zeroFreqDcCurrent))
    else $error("two zero frequency outputs at once");
  a_section_max: assert property (
    decelScurveStartTime <= MAX_SECTION_TIME &&
    decelScurveEndTime <= MAX_SECTION_TIME)
    else $error("S-curve section above range");
  a_current_max: assert property (
    shortBrakeCurrent <= MAX_SHORT_CURRENT)
    else $error("short brake current above range");
  a_end_written: assert property ($changed(decelScurveEndTime) |->
    $past(wEnd) || $past(wEnd, 2))
    else $error("S-curve end time changed without write");
  a_cur_written: assert property ($changed(shortBrakeCurrent) |->
    $past(wCur) || $past(wCur, 2))
    else $error("short brake current changed without write");
endmodule : rss_sequencer_assertions
bind rss_sequencer rss_sequencer_assertions u_chk (.mclk(mclk),
  .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .setBelowLimit(setBelowLimit), .driveEnable(driveEnable),
  .runAtLowerLimit(runAtLowerLimit), .shortBrakeActive(shortBrakeActive),
  .dcBrakeActive(dcBrakeActive), .zeroFreqVoltage(zeroFreqVoltage),
  .zeroFreqDcCurrent(zeroFreqDcCurrent),
  .shortBrakeCurrent(shortBrakeCurrent),
  .decelScurveStartTime(decelScurveStartTime),
  .decelScurveEndTime(decelScurveEndTime));

// *** verification/rss_sequencer_tb.sv ***
// Self-checking bench for the run/sleep/restart sequencer.
// Assumes a tick of four clocks, so a hold of N ticks (N above 0) lasts 4N-2 to 4N+1 cycles.
`timescale 1ns/1ps
module rss_sequencer_tb
  import rss_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, rdv;
  logic setBelowLimit = 1'b0, runBelowLimit = 1'b0;
  logic belowBrakeFreq = 1'b0, atZeroFreq = 1'b0;
  logic driveEnable, runAtLowerLimit, shortBrakeActive, dcBrakeActive;
  logic zeroFreqVoltage, zeroFreqDcCurrent;
  logic [15:0] shortBrakeCurrent, decelScurveStartTime, decelScurveEndTime;
  logic [15:0] emergencyDecelTime, stopSpeedHoldDelay;
  int error_cnt = 0, comparisons = 0, i;
  logic [20:0] rstT [14] = '{{ADDR_LIMIT_ACTION, 16'h0000},
    {ADDR_WAKE_DELAY, 16'h0000}, {ADDR_RESTART_EN, 16'h0000},
    {ADDR_RESTART_WAIT, 16'h000a}, {ADDR_START_DELAY, 16'h0000},
    {ADDR_STOP_HOLD_DLY, 16'h0000}, {ADDR_ZERO_FREQ_SEL, 16'h0000},
    {ADDR_EMERG_DECEL, 16'h0014}, {ADDR_SCURVE_START, 16'h0001},
    {ADDR_SCURVE_END, 16'h0001}, {ADDR_SHORT_CURRENT, 16'h0000},
    {ADDR_SHORT_START, 16'h0000}, {ADDR_SHORT_STOP, 16'h0000},
    {ADDR_DC_STOP_TIME, 16'h0000}};
  logic [20:0] clT [9] = '{{ADDR_WAKE_DELAY, 16'h8ca0},
    {ADDR_RESTART_WAIT, 16'h8ca0}, {ADDR_START_DELAY, 16'h1770},
    {ADDR_SCURVE_START, 16'h01f4}, {ADDR_SCURVE_END, 16'h01f4},
    {ADDR_SHORT_CURRENT, 16'h05dc}, {ADDR_SHORT_START, 16'h01f4},
    {ADDR_SHORT_STOP, 16'h01f4}, {ADDR_DC_STOP_TIME, 16'h01f4}};
  always #12.5 mclk = ~mclk;
  rss_sequencer #(.TICK_DIV(4)) DUT (.mclk(mclk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .setBelowLimit(setBelowLimit),
    .runBelowLimit(runBelowLimit), .belowBrakeFreq(belowBrakeFreq),
    .atZeroFreq(atZeroFreq), .driveEnable(driveEnable),
    .runAtLowerLimit(runAtLowerLimit), .shortBrakeActive(shortBrakeActive),
    .dcBrakeActive(dcBrakeActive), .zeroFreqVoltage(zeroFreqVoltage),
    .zeroFreqDcCurrent(zeroFreqDcCurrent),
    .shortBrakeCurrent(shortBrakeCurrent),
    .decelScurveStartTime(decelScurveStartTime),
    .decelScurveEndTime(decelScurveEndTime),
    .emergencyDecelTime(emergencyDecelTime),
    .stopSpeedHoldDelay(stopSpeedHoldDelay));
  task automatic complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(posedge mclk);
    rdv = regRdata;
  endtask : rd
  task automatic chkRd(input logic [4:0] a, input logic [15:0] e);
    rd(a);
    chk(rdv, e);
  endtask : chkRd
  // Bits: drive, lower-limit clamp, short brake, DC brake
  task automatic chkOut(input logic [3:0] e, input logic [3:0] m);
    chk({12'h000, {driveEnable, runAtLowerLimit, shortBrakeActive,
      dcBrakeActive} & m}, {12'h000, e});
  endtask : chkOut
  task automatic waitSt(input logic [7:0] st);
    for (int n = 0; n < 100; n++) begin
      rd(ADDR_STATUS);
      if (rdv[7:0] === st) break;
    end
    chk({8'h00, rdv[7:0]}, {8'h00, st});
    if (rdv[7:0] !== st) complete_run();
  endtask : waitSt
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    for (i = 0; i < 14; i++) begin
      chkRd(rstT[i][20:16], rstT[i][15:0]);
    end
    chk({14'h0, zeroFreqVoltage, zeroFreqDcCurrent}, 16'h0000);
    chk(decelScurveStartTime, 16'h0001);
    chk(emergencyDecelTime, 16'h0014);
    chk(stopSpeedHoldDelay, 16'h0000);
    for (i = 0; i < 9; i++) begin
      wr(clT[i][20:16], 16'hffff);
      chkRd(clT[i][20:16], clT[i][15:0]);
    end
    chk(decelScurveEndTime, 16'h01f4);
    chk(shortBrakeCurrent, 16'h05dc);
    for (i = 0; i < 9; i++) wr(clT[i][20:16], 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_LIMIT_ACTION, 16'(i));
      chkRd(ADDR_LIMIT_ACTION, (i == 3) ? 16'h0002 : 16'(i));
      wr(ADDR_ZERO_FREQ_SEL, 16'(i));
      chkRd(ADDR_ZERO_FREQ_SEL, (i == 3) ? 16'h0002 : 16'(i));
    end
    wr(ADDR_LIMIT_ACTION, 16'h0000);
    wr(ADDR_ZERO_FREQ_SEL, 16'h0000);
    wr(ADDR_START_MODE, 16'h0000);
    chkRd(5'h1f, 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    waitSt(ST_RUN);
    setBelowLimit <= 1'b1;
    repeat (3) @(posedge mclk);
    chkOut(4'hc, 4'hc);
    atZeroFreq <= 1'b1;
    for (i = 1; i < 3; i++) begin
      wr(ADDR_ZERO_FREQ_SEL, 16'(i));
      repeat (2) @(posedge mclk);
      chk({14'h0, zeroFreqVoltage, zeroFreqDcCurrent}, 16'(3 - i));
    end
    wr(ADDR_ZERO_FREQ_SEL, 16'h0000);
    atZeroFreq <= 1'b0;
    wr(ADDR_LIMIT_ACTION, 16'h0001);
    repeat (3) @(posedge mclk);
    chkOut(4'h0, 4'h8);
    setBelowLimit <= 1'b0;
    repeat (3) @(posedge mclk);
    chkOut(4'h8, 4'h8);
    wr(ADDR_WAKE_DELAY, 16'h0003);
    wr(ADDR_LIMIT_ACTION, 16'h0002);
    setBelowLimit <= 1'b1;
    runBelowLimit <= 1'b1;
    waitSt(ST_SLEEP);
    chkOut(4'h0, 4'h8);
    // Broken spells shorter than the wake delay must not wake it
    runBelowLimit <= 1'b0;
    setBelowLimit <= 1'b0;
    repeat (6) @(posedge mclk);
    setBelowLimit <= 1'b1;
    repeat (2) @(posedge mclk);
    setBelowLimit <= 1'b0;
    repeat (3) @(posedge mclk);
    chkRd(ADDR_STATUS, 16'h0020);
    waitSt(ST_RUN);
    wr(ADDR_LIMIT_ACTION, 16'h0000);
    wr(ADDR_SHORT_STOP, 16'h0003);
    wr(ADDR_DC_STOP_TIME, 16'h0003);
    belowBrakeFreq <= 1'b1;
    wr(ADDR_CTRL, 16'h0000);
    waitSt(ST_SHORT_STOP);
    chkOut(4'h2, 4'h3);
    waitSt(ST_DC_STOP);
    chkOut(4'h1, 4'h3);
    waitSt(ST_IDLE);
    belowBrakeFreq <= 1'b0;
    wr(ADDR_START_DELAY, 16'h0003);
    wr(ADDR_SHORT_START, 16'h0003);
    wr(ADDR_CTRL, 16'h0001);
    chkRd(ADDR_STATUS, 16'h0004);
    chkOut(4'h0, 4'h8);
    waitSt(ST_SHORT_START);
    chkOut(4'h2, 4'h2);
    waitSt(ST_RUN);
    belowBrakeFreq <= 1'b1;
    wr(ADDR_CTRL, 16'h0000);
    waitSt(ST_IDLE);
    wr(ADDR_START_DELAY, 16'h0000);
    wr(ADDR_SHORT_START, 16'h0000);
    wr(ADDR_CTRL, 16'h0002);
    repeat (20) @(posedge mclk);
    chkRd(ADDR_STATUS, 16'h0001);
    wr(ADDR_RESTART_WAIT, 16'h0003);
    wr(ADDR_RESTART_EN, 16'h0001);
    waitSt(ST_PWR_WAIT);
    waitSt(ST_RUN);
    chk(rdv, 16'h0110);
    complete_run();
  end
endmodule : rss_sequencer_tb
